// *** dv/rtc_values_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bus-side checks, ports of the top only
// ----------------------------------------
module rtc_values_asserts #(
   parameter int half_cycles = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   wire logic acc = psel && penable;
   wire logic rd = psel && penable && !pwrite;
   wire logic mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
   wire logic win = paddr inside {12'h004, 12'h008, 12'h00c, 12'h010};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_in_access: assert property (acc |-> pready) else $error("access phase without ready");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("unmapped access without error");
   a_err_mapped_none: assert property (acc && mapped |-> !pslverr) else $error("error on a mapped register");
   a_err_only_access: assert property (pslverr |-> psel && penable) else $error("error outside access phase");
   a_unmapped_reads_zero: assert property (rd && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
   a_window_upper_zero: assert property (rd && win |-> prdata[31:8] == 24'h0) else $error("window pad bits set");
   a_control_pad_zero: assert property (rd && paddr == 12'h000 |-> (prdata & 32'hfffffccc) == 32'h0)
      else $error("control pad bits set");
   a_status_pad_zero: assert property (rd && paddr == 12'h014 |-> prdata[31:1] == 31'h0)
      else $error("status pad bits set");
   // read data must survive into the idle cycle after the access
   a_read_data_hold: assert property (rd |=> $stable(prdata)) else $error("read data moved after access");
endmodule

bind rtc_values rtc_values_asserts #(.half_cycles(half_cycles)) rtc_values_asserts_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** dv/rtc_values_bench.sv ***
`timescale 1ns/1ps
module rtc_values_bench;
   // short half-second so a whole second passes in 80 cycles
   localparam int half_cycles = 40;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int fail_count = 0;
   int n_compared = 0;
   integer seed = 32'hd32a9d88;
   logic [15:0] tm [4];
   logic [15:0] al [4];
   bit run_now;
   bit wren_now;
   logic [31:0] r;
   logic [15:0] v;

   always #2.5 pclk = ~pclk;

   rtc_values #(.half_cycles(half_cycles)) rtc_values_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ----------------------------------------
   // bus master and model access
   // ----------------------------------------
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rdv);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) fail_count++;
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge keeps two requests from landing in one time step
      @(posedge pclk);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic ctl(input logic [1:0] p);
      apb(1'b1, rtc_values_pkg::off_control, {22'h0, p, 2'h0, p, 2'h0, wren_now, run_now}, r);
   endtask

   function automatic logic [15:0] msk(input bit a, input int i);
      case (i)
         0: return rtc_values_pkg::mask_minutes_seconds;
         1: return rtc_values_pkg::mask_weekday_hours;
         2: return rtc_values_pkg::mask_month_day;
         default: return a ? 16'h0 : rtc_values_pkg::mask_year;
      endcase
   endfunction

   // low half first: the high access moves the pointer on
   task automatic wword(input bit a, input int i, input logic [15:0] d);
      ctl(i[1:0]);
      apb(1'b1, a ? 12'h010 : 12'h008, {16'h0, d}, r);
      apb(1'b1, a ? 12'h00c : 12'h004, {16'h0, d}, r);
      if (wren_now && a) al[i] = d & msk(1'b1, i);
      if (wren_now && !a) tm[i] = d & msk(1'b0, i);
   endtask

   task automatic rword(input bit a, input int i);
      ctl(i[1:0]);
      apb(1'b0, a ? 12'h010 : 12'h008, 32'h0, r);
      v[7:0] = r[7:0];
      apb(1'b0, a ? 12'h00c : 12'h004, 32'h0, r);
      v[15:8] = r[7:0];
      chk(a ? "alarm word" : "time word", {16'h0, a ? al[i] : tm[i]}, {16'h0, v});
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #50000;
      fail_count++;
      print_verdict();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      run_now = 1'b0;
      wren_now = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, rtc_values_pkg::off_control, 32'h0, r);
      chk("control after reset", 32'h0, r);
      // value words carry no reset: implemented bits unknown, pad bits zero
      for (int i = 0; i < 4; i++) begin
         tm[i] = tm[i] & msk(1'b0, i);
         al[i] = al[i] & msk(1'b1, i);
      end
      for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) rword(a[0], i);
      repeat (2) for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) wword(a[0], i, 16'($random(seed)));
      for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) rword(a[0], i);
      ctl(2'h2);
      apb(1'b1, 12'h004, {16'h0, tm[2]}, r);
      apb(1'b0, 12'h00c, 32'h0, r);
      apb(1'b0, rtc_values_pkg::off_control, 32'h0, r);
      chk("pointers", {22'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2}, r);
      wren_now = 1'b0;
      for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) wword(a[0], i, 16'($random(seed)));
      for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) rword(a[0], i);
      apb(1'b1, 12'h018, 32'hffffffff, r);
      apb(1'b0, 12'h020, 32'h0, r);
      chk("unmapped read", 32'h0, r);
      wren_now = 1'b1;
      run_now = 1'b1;
      ctl(2'h0);
      for (int n = 0; n < 100 && r[0] !== 1'b1; n++) apb(1'b0, rtc_values_pkg::off_status, 32'h0, r);
      chk("half second seen", 32'h1, r);
      apb(1'b1, 12'h008, 32'h0, r);
      apb(1'b0, rtc_values_pkg::off_status, 32'h0, r);
      chk("half second cleared", 32'h0, r);
      run_now = 1'b0;
      wword(1'b0, 0, 16'h5959);
      wword(1'b0, 1, 16'h0623);
      wword(1'b0, 2, 16'h1231);
      wword(1'b0, 3, 16'h0049);
      run_now = 1'b1;
      ctl(2'h0);
      r = 32'h59;
      for (int n = 0; n < 100 && r[7:0] === 8'h59; n++) apb(1'b0, 12'h008, 32'h0, r);
      run_now = 1'b0;
      ctl(2'h0);
      tm[0] = 16'h0000;
      tm[1] = 16'h0000;
      tm[2] = 16'h0101;
      tm[3] = 16'h0050;
      for (int i = 0; i < 4; i++) for (int a = 0; a < 2; a++) rword(a[0], i);
      print_verdict();
   end
endmodule

// *** hw/rtc_values.sv ***
`timescale 1ns/1ps
// How it works
// - month tens digit is one bit at bit 12 of month/day, both copies
// - month units digit is BCD at bits 11..8 of month/day
// - day tens digit sits at bits 5..4 of month/day
// - day units digit is BCD at bits 3..0 of month/day
// - weekday digit sits at bits 10..8 of weekday/hours
// - hours tens digit sits at bits 5..4 of weekday/hours
// - hours units digit is BCD at bits 3..0 of weekday/hours
// - minutes tens digit sits at bits 14..12 of minutes/seconds
// - minutes units digit is BCD at bits 11..8 of minutes/seconds
// - seconds tens digit sits at bits 6..4 of minutes/seconds
// - seconds units digit is BCD at bits 3..0 of minutes/seconds
// - date and hour words accept writes only while write enable is one
// - unimplemented bits of every value word read as zero
// - digit fields have no reset value; unknown until written
// - time pointer picks window word, decrements after high access down to zero
// - alarm pointer picks alarm word, decrements after high access down to zero
// - time window is locked against writes while write enable is zero
// - writing low half of time minutes/seconds clears half-second status
module rtc_values #(
   parameter int half_cycles = rtc_values_pkg::half_second_cycles
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   rtc_values_pkg::control_t ctl;
   rtc_values_pkg::value_set_t tv;
   rtc_values_pkg::value_set_t av;
   logic [7:0] year;
   logic half;
   logic [31:0] div;
   logic half_tick;

   wire logic acc = psel & penable;
   wire logic wr = acc & pwrite;
   wire logic hit_ctl = paddr == rtc_values_pkg::off_control;
   wire logic hit_th = paddr == rtc_values_pkg::off_time_high;
   wire logic hit_tl = paddr == rtc_values_pkg::off_time_low;
   wire logic hit_ah = paddr == rtc_values_pkg::off_alarm_high;
   wire logic hit_al = paddr == rtc_values_pkg::off_alarm_low;
   wire logic hit_st = paddr == rtc_values_pkg::off_status;
   wire logic mapped = hit_ctl | hit_th | hit_tl | hit_ah | hit_al | hit_st;

   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // BCD increment with wrap at max; returns carry in bit 4
   function automatic logic [4:0] bcd_inc(input logic [3:0] d, input logic [3:0] max);
      if (d >= max) begin
         bcd_inc = {1'b1, 4'h0};
      end else begin
         bcd_inc = {1'b0, 4'(d + 4'h1)};
      end
   endfunction

   // window word selected by pointer, low 16 = low half
   function automatic logic [31:0] window(input rtc_values_pkg::value_set_t v, input logic [7:0] y,
                                          input logic [1:0] p, input logic is_alarm);
      logic [15:0] w;
      w = 16'h0000;
      unique case (p)
         rtc_values_pkg::ptr_min_sec: w = v.minutes_seconds & rtc_values_pkg::mask_minutes_seconds;
         rtc_values_pkg::ptr_wkdy_hr: w = v.weekday_hours & rtc_values_pkg::mask_weekday_hours;
         rtc_values_pkg::ptr_mth_day: w = v.month_day & rtc_values_pkg::mask_month_day;
         rtc_values_pkg::ptr_year: w = is_alarm ? 16'h0000 : {8'h00, y};
      endcase
      window = {16'h0000, w};
   endfunction

   // ----------------------------------------
   // half-second divider
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 32'h0;
      end else if (!ctl.run || half_tick) begin
         div <= 32'h0;
      end else begin
         div <= div + 32'h1;
      end
   end
   assign half_tick = ctl.run && (div == 32'(half_cycles - 1));

   // ----------------------------------------
   // control register and pointers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= '0;
      end else if (wr && hit_ctl && pstrb[0] && pstrb[1]) begin
         ctl.run <= pwdata[rtc_values_pkg::ctl_run_bit];
         ctl.wren <= pwdata[rtc_values_pkg::ctl_wren_bit];
         ctl.tptr <= pwdata[rtc_values_pkg::ctl_tptr_lsb +: 2];
         ctl.aptr <= pwdata[rtc_values_pkg::ctl_aptr_lsb +: 2];
      end else begin
         if (acc && hit_th && ctl.tptr != rtc_values_pkg::ptr_min_sec) begin
            ctl.tptr <= ctl.tptr - 2'h1;
         end
         if (acc && hit_ah && ctl.aptr != rtc_values_pkg::ptr_min_sec) begin
            ctl.aptr <= ctl.aptr - 2'h1;
         end
      end
   end

   // ----------------------------------------
   // half-second status
   // ----------------------------------------
   wire logic tw_ok = ctl.wren;
   wire logic clr_half = wr && hit_tl && pstrb[0] && tw_ok && ctl.tptr == rtc_values_pkg::ptr_min_sec;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half <= 1'b0;
      end else if (clr_half) begin
         half <= 1'b0;
      end else if (half_tick) begin
         half <= ~half;
      end
   end

   // ----------------------------------------
   // time words: software write and counting
   // ----------------------------------------
   wire logic sec_tick = half_tick && half && !clr_half;
   logic [4:0] s1, s10, m1, m10, h1, d1, mo1, y1, y10;
   logic hr_wrap, day_wrap, mon_wrap;
   logic [3:0] dmax;
   always_comb begin
      s1 = bcd_inc(tv.minutes_seconds[3:0], 4'h9);
      s10 = bcd_inc({1'b0, tv.minutes_seconds[6:4]}, 4'h5);
      m1 = bcd_inc(tv.minutes_seconds[11:8], 4'h9);
      m10 = bcd_inc({1'b0, tv.minutes_seconds[14:12]}, 4'h5);
      h1 = bcd_inc(tv.weekday_hours[3:0], 4'h9);
      hr_wrap = tv.weekday_hours[5:4] == 2'h2 && tv.weekday_hours[3:0] == 4'h3;
      d1 = bcd_inc(tv.month_day[3:0], 4'h9);
      dmax = 4'h1;
      day_wrap = tv.month_day[5:4] == 2'h3 && tv.month_day[3:0] >= dmax;
      mo1 = bcd_inc(tv.month_day[11:8], 4'h9);
      mon_wrap = tv.month_day[12] && tv.month_day[11:8] == 4'h2;
      y1 = bcd_inc(year[3:0], 4'h9);
      y10 = bcd_inc(year[7:4], 4'h9);
   end

   always_ff @(posedge pclk) begin
      if (wr && hit_th && tw_ok) begin
         unique case (ctl.tptr)
            rtc_values_pkg::ptr_min_sec: if (pstrb[1]) tv.minutes_seconds[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_wkdy_hr: if (pstrb[1]) tv.weekday_hours[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_mth_day: if (pstrb[1]) tv.month_day[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_year: ;
         endcase
      end else if (wr && hit_tl && tw_ok) begin
         unique case (ctl.tptr)
            rtc_values_pkg::ptr_min_sec: if (pstrb[0]) tv.minutes_seconds[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_wkdy_hr: if (pstrb[0]) tv.weekday_hours[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_mth_day: if (pstrb[0]) tv.month_day[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_year: if (pstrb[0]) year <= pwdata[7:0];
         endcase
      end else if (sec_tick) begin
         tv.minutes_seconds[3:0] <= s1[3:0];
         if (s1[4]) begin
            tv.minutes_seconds[6:4] <= s10[2:0];
            if (s10[4]) begin
               tv.minutes_seconds[11:8] <= m1[3:0];
               if (m1[4]) begin
                  tv.minutes_seconds[14:12] <= m10[2:0];
                  if (m10[4]) begin
                     if (hr_wrap) begin
                        tv.weekday_hours[5:0] <= 6'h00;
                        tv.weekday_hours[10:8] <= (tv.weekday_hours[10:8] >= 3'h6) ? 3'h0
                                                  : 3'(tv.weekday_hours[10:8] + 3'h1);
                        if (day_wrap) begin
                           tv.month_day[5:0] <= 6'h01;
                           if (mon_wrap) begin
                              tv.month_day[12:8] <= 5'h01;
                              year[3:0] <= y1[3:0];
                              if (y1[4]) begin
                                 year[7:4] <= y10[3:0];
                              end
                           end else if (mo1[4]) begin
                              tv.month_day[12:8] <= 5'h10;
                           end else begin
                              tv.month_day[11:8] <= mo1[3:0];
                           end
                        end else begin
                           tv.month_day[3:0] <= d1[3:0];
                           if (d1[4]) begin
                              tv.month_day[5:4] <= 2'(tv.month_day[5:4] + 2'h1);
                           end
                        end
                     end else begin
                        tv.weekday_hours[3:0] <= h1[3:0];
                        if (h1[4]) begin
                           tv.weekday_hours[5:4] <= 2'(tv.weekday_hours[5:4] + 2'h1);
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------
   // alarm words: software only
   // ----------------------------------------
   // only software writes alarm words
   always_ff @(posedge pclk) begin
      if (wr && hit_ah && ctl.wren && pstrb[1]) begin
         unique case (ctl.aptr)
            rtc_values_pkg::ptr_min_sec: av.minutes_seconds[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_wkdy_hr: av.weekday_hours[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_mth_day: av.month_day[15:8] <= pwdata[15:8];
            rtc_values_pkg::ptr_year: ;
         endcase
      end else if (wr && hit_al && ctl.wren && pstrb[0]) begin
         unique case (ctl.aptr)
            rtc_values_pkg::ptr_min_sec: av.minutes_seconds[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_wkdy_hr: av.weekday_hours[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_mth_day: av.month_day[7:0] <= pwdata[7:0];
            rtc_values_pkg::ptr_year: ;
         endcase
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [31:0] tw, aw;
   always_comb begin
      tw = window(tv, year, ctl.tptr, 1'b0);
      aw = window(av, 8'h00, ctl.aptr, 1'b1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0;
         if (hit_ctl) begin
            prdata[rtc_values_pkg::ctl_run_bit] <= ctl.run;
            prdata[rtc_values_pkg::ctl_wren_bit] <= ctl.wren;
            prdata[rtc_values_pkg::ctl_tptr_lsb +: 2] <= ctl.tptr;
            prdata[rtc_values_pkg::ctl_aptr_lsb +: 2] <= ctl.aptr;
         end else if (hit_th) begin
            prdata <= {24'h0, tw[15:8]};
         end else if (hit_tl) begin
            prdata <= {24'h0, tw[7:0]};
         end else if (hit_ah) begin
            prdata <= {24'h0, aw[15:8]};
         end else if (hit_al) begin
            prdata <= {24'h0, aw[7:0]};
         end else if (hit_st) begin
            prdata[rtc_values_pkg::stat_half_bit] <= half;
         end
      end
   end

endmodule

// *** hw/rtc_values_pkg.sv ***
package rtc_values_pkg;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [11:0] off_control = 12'h000;
   localparam logic [11:0] off_time_high = 12'h004;
   localparam logic [11:0] off_time_low = 12'h008;
   localparam logic [11:0] off_alarm_high = 12'h00c;
   localparam logic [11:0] off_alarm_low = 12'h010;
   localparam logic [11:0] off_status = 12'h014;

   // ----------------------------------------
   // control and status register fields
   // ----------------------------------------
   localparam int ctl_run_bit = 0;
   localparam int ctl_wren_bit = 1;
   localparam int ctl_tptr_lsb = 4;
   localparam int ctl_aptr_lsb = 8;
   localparam int stat_half_bit = 0;

   // ----------------------------------------
   // pointer codes
   // ----------------------------------------
   localparam logic [1:0] ptr_min_sec = 2'h0;
   localparam logic [1:0] ptr_wkdy_hr = 2'h1;
   localparam logic [1:0] ptr_mth_day = 2'h2;
   localparam logic [1:0] ptr_year = 2'h3;

   // ----------------------------------------
   // implemented-bit masks of each word
   // ----------------------------------------
   localparam logic [15:0] mask_month_day = 16'h1f3f;
   localparam logic [15:0] mask_weekday_hours = 16'h073f;
   localparam logic [15:0] mask_minutes_seconds = 16'h7f7f;
   localparam logic [15:0] mask_year = 16'h00ff;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int clk_mhz = 200;
   localparam int half_second_ms = 500;
   localparam int half_second_cycles = half_second_ms * 1000 * clk_mhz;

   typedef struct packed {
      logic run;
      logic wren;
      logic [1:0] tptr;
      logic [1:0] aptr;
   } control_t;

   typedef struct packed {
      logic [15:0] month_day;
      logic [15:0] weekday_hours;
      logic [15:0] minutes_seconds;
   } value_set_t;

endpackage
